// file: rtl/pmdr_pkg.sv
package pmdr_pkg;
  localparam logic [7:0] ofs_hot_swap    = 8'h40;
  localparam logic [7:0] ofs_vendor_cap  = 8'h48;
  localparam logic [7:0] ofs_fifo_status = 8'h4C;
  localparam logic [7:0] ofs_pci_addr    = 8'h50;
  localparam logic [7:0] ofs_be_addr     = 8'h54;
  localparam logic [7:0] ofs_byte_count  = 8'h58;
  localparam logic [7:0] ofs_dma_control = 8'h5C;
  localparam logic [7:0] cap_id_vendor   = 8'h09;
  localparam logic [7:0] cap_next_ptr    = 8'h40;
  localparam logic [7:0] cap_id_hot_swap = 8'h06;
  localparam logic [7:0] cap_size_master = 8'h18;
  localparam int hs_enum_mask  = 17;
  localparam int hs_pending    = 18;
  localparam int hs_led        = 19;
  localparam int hs_extract    = 22;
  localparam int hs_insert     = 23;
  localparam int dc_done       = 2;
  localparam int dc_request    = 3;
  localparam int dc_enable     = 8;
  localparam int dc_wide       = 9;
  localparam int dc_flush      = 10;
  localparam int dc_irq_stat   = 12;
  localparam int dc_irq_en     = 13;
  localparam int dc_be_stat    = 14;
  localparam int dc_be_en      = 15;
  localparam logic [2:0] bar_direct = 3'h7;
  localparam logic [1:0] st_ok        = 2'h0;
  localparam logic [1:0] st_mabort    = 2'h1;
  localparam logic [1:0] st_parity    = 2'h2;
  localparam logic [1:0] st_tabort    = 2'h3;
  localparam logic [31:0] direct_count = 32'h0000_0004;
endpackage

// file: rtl/pmdr_fifo.sv
`timescale 1ns/1ps
module pmdr_fifo #(
  parameter int width = 32,
  parameter int depth = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [width-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [width-1:0]      out_data,
  // fill level
  output logic [$clog2(depth):0] level
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wr_ptr;
  logic [aw-1:0]    rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (level != depth[aw:0]);
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        level <= level + 1'b1;
      end else if (do_rd && !do_wr) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

// file: rtl/pmdr_regs.sv
`timescale 1ns/1ps
module pmdr_regs #(
  parameter logic [1:0] dma_regs_location_param = 2'h1,
  parameter logic [2:0] dma_regs_bar_param      = 3'h0,
  parameter bit         backend_access_param    = 1'b1,
  parameter bit         no_window_overflow_param = 1'b0,
  parameter bit         no_wait_timer_param     = 1'b0,
  parameter bit         fifo_recovery_param     = 1'b1,
  parameter bit         direct_transfer_param   = 1'b0,
  parameter bit         wide_param              = 1'b0,
  parameter int         backend_addr_bits_param = 20,
  parameter int         count_bits_param        = 12,
  parameter int         fifo_depth              = 16
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // configuration register access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  // system state
  input  wire logic        bus_master_en,
  input  wire logic        extract_event,
  input  wire logic        insert_event,
  input  wire logic        backend_irq_n,
  input  wire logic [5:0]  ext_fifo_nonempty,
  output logic             enum_signal_mask,
  output logic             led_on_off,
  output logic             irq_active,
  // pci master engine
  output logic             xfer_start,
  output logic [31:0]      xfer_pci_addr,
  output logic [3:0]       pci_command,
  output logic [7:0]       lane_enable_n,
  output logic             xfer_wide,
  output logic [2:0]       backend_bar,
  output logic [7:0]       burst_phases,
  input  wire logic        phase_done,
  input  wire logic        xfer_end,
  input  wire logic [1:0]  xfer_status,
  // backend write data path
  input  wire logic        be_valid,
  output logic             be_ready,
  input  wire logic [31:0] be_data,
  // pci side data and backend address
  output logic             pci_valid,
  input  wire logic        pci_ready,
  output logic [31:0]      pci_data,
  output logic [31:0]      xfer_be_addr,
  output logic             xfer_active
);
  //--------------------------------------------------------------
  // register state
  //--------------------------------------------------------------
  logic [31:0] pci_addr;
  logic [31:0] be_addr;
  logic [31:0] byte_count;
  logic [31:0] dctl;
  logic        hs_ext;
  logic        hs_ins;
  logic        hs_eim;
  logic        hs_loo;
  logic        ext_irq_stat;
  logic        ext_irq_en;
  logic        irq_n_q;
  logic        flush;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] cnt_left;
  logic [4:0]  q_level;
  logic [31:0] be_mask;
  logic        sel_hs;
  logic        sel_cap;
  logic        sel_fs;
  logic        sel_pa;
  logic        sel_ba;
  logic        sel_bc;
  logic        sel_dc;
  logic        request;
  logic        next_dctl_req;

  assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign sel_hs  = cfg_addr == pmdr_pkg::ofs_hot_swap;
  assign sel_cap = cfg_addr == pmdr_pkg::ofs_vendor_cap;
  assign sel_fs  = cfg_addr == pmdr_pkg::ofs_fifo_status;
  assign sel_pa  = cfg_addr == pmdr_pkg::ofs_pci_addr;
  assign sel_ba  = cfg_addr == pmdr_pkg::ofs_be_addr;
  assign sel_bc  = cfg_addr == pmdr_pkg::ofs_byte_count;
  assign sel_dc  = cfg_addr == pmdr_pkg::ofs_dma_control;
  assign request = dctl[pmdr_pkg::dc_request];

  // outside direct transfer builds, bits beyond the backend width stay zero
  assign be_mask = direct_transfer_param ? 32'hFFFF_FFFF :
                   ((32'h1 << backend_addr_bits_param) - 32'h1) & 32'hFFFF_FFFC;

  always_comb begin
    wval = (cfg_wdata & wmask);
  end

  //--------------------------------------------------------------
  // hot-swap
  //--------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hs_ext <= 1'b0;
      hs_ins <= 1'b0;
      hs_eim <= 1'b0;
      hs_loo <= 1'b0;
    end else begin
      if (extract_event) begin
        hs_ext <= 1'b1;
      end else if (cfg_wr && sel_hs && wval[pmdr_pkg::hs_extract]) begin
        hs_ext <= 1'b0;
      end
      if (insert_event) begin
        hs_ins <= 1'b1;
      end else if (cfg_wr && sel_hs && wval[pmdr_pkg::hs_insert]) begin
        hs_ins <= 1'b0;
      end
      if (cfg_wr && sel_hs && cfg_be[2]) begin
        hs_eim <= cfg_wdata[pmdr_pkg::hs_enum_mask];
        hs_loo <= cfg_wdata[pmdr_pkg::hs_led];
      end
    end
  end

  //--------------------------------------------------------------
  // external interrupt, latched in control bit 14
  //--------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_n_q      <= 1'b1;
      ext_irq_stat <= 1'b0;
      ext_irq_en   <= 1'b0;
    end else begin
      irq_n_q <= backend_irq_n;
      if (!irq_n_q && ext_irq_en) begin
        ext_irq_stat <= 1'b1;
      end else if (cfg_wr && sel_dc && wval[pmdr_pkg::dc_be_stat]) begin
        ext_irq_stat <= 1'b0;
      end
      if (cfg_wr && sel_dc && cfg_be[1]) begin
        ext_irq_en <= cfg_wdata[pmdr_pkg::dc_be_en];
      end
    end
  end

  //--------------------------------------------------------------
  // dma control
  //--------------------------------------------------------------
  // the request stays set until the engine reports the end or a byte 0 control write recomputes it
  assign next_dctl_req = cfg_wdata[pmdr_pkg::dc_request] && bus_master_en &&
                         cfg_wdata[pmdr_pkg::dc_enable];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dctl       <= 32'h0000_0000;
      xfer_start <= 1'b0;
    end else begin
      xfer_start <= 1'b0;
      if (cfg_wr && sel_dc) begin
        // a write mid-transfer disturbs it; software polls request first
        if (cfg_be[0]) begin
          dctl[7:4] <= cfg_wdata[7:4];
          dctl[1:0] <= cfg_wdata[1:0];
          if (!cfg_wdata[pmdr_pkg::dc_done]) begin
            dctl[pmdr_pkg::dc_done] <= 1'b0;
          end
          dctl[pmdr_pkg::dc_request] <= next_dctl_req;
          xfer_start <= next_dctl_req && !request;
        end
        if (cfg_be[1]) begin
          dctl[pmdr_pkg::dc_enable] <= cfg_wdata[pmdr_pkg::dc_enable];
          dctl[pmdr_pkg::dc_wide]   <= cfg_wdata[pmdr_pkg::dc_wide] & wide_param;
          dctl[pmdr_pkg::dc_irq_en] <= cfg_wdata[pmdr_pkg::dc_irq_en];
          if (cfg_wdata[pmdr_pkg::dc_irq_stat]) begin
            dctl[pmdr_pkg::dc_irq_stat] <= 1'b0;
          end
        end
        if (cfg_be[2]) begin
          dctl[23:16] <= wide_param ? cfg_wdata[23:16] : {4'h0, cfg_wdata[19:16]};
        end
        if (cfg_be[3]) begin
          dctl[28:26] <= cfg_wdata[28:26];
          dctl[31:29] <= cfg_wdata[31:29];
        end
      end
      // hardware events win over a software clear in the same cycle
      if (xfer_end && request) begin
        dctl[pmdr_pkg::dc_request] <= 1'b0;
        dctl[pmdr_pkg::dc_done]    <= 1'b1;
        dctl[1:0]                  <= xfer_status;
        if (dctl[pmdr_pkg::dc_irq_en]) begin
          dctl[pmdr_pkg::dc_irq_stat] <= 1'b1;
        end
      end
    end
  end

  // burst cap of 2^(n-1) phases, zero means no cap
  always_comb begin
    burst_phases = (dctl[31:29] == 3'h0) ? 8'h00 :
                   8'(8'h01 << (dctl[31:29] - 3'h1));
  end

  //--------------------------------------------------------------
  // address and count registers
  //--------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pci_addr   <= 32'h0000_0000;
      be_addr    <= 32'h0000_0000;
      byte_count <= 32'h0000_0000;
    end else begin
      if (cfg_wr && sel_pa) begin
        pci_addr <= (pci_addr & ~wmask) | wval;
      end else if (phase_done && request) begin
        pci_addr <= pci_addr + (dctl[pmdr_pkg::dc_wide] ? 32'h8 : 32'h4);
      end
      if (cfg_wr && sel_ba) begin
        be_addr <= ((be_addr & ~wmask) | wval) &
                   (direct_transfer_param ? 32'hFFFF_FFFF : be_mask);
      end else if (phase_done && request && backend_bar != pmdr_pkg::bar_direct) begin
        be_addr <= (be_addr + (dctl[pmdr_pkg::dc_wide] ? 32'h8 : 32'h4)) & be_mask;
      end else if (direct_transfer_param && pci_ready && pci_valid == 1'b0 &&
                   backend_bar == pmdr_pkg::bar_direct && phase_done) begin
        be_addr <= be_addr;
      end
      if (cfg_wr && sel_bc) begin
        byte_count <= ((byte_count & ~wmask) | wval) & 32'hFFFF_FFFC;
      end
    end
  end

  // zero count means the full range of the count width
  assign cnt_left = (byte_count == 32'h0) ? (32'h1 << count_bits_param) : byte_count;

  //--------------------------------------------------------------
  // flush strobe
  //--------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flush <= 1'b0;
    end else begin
      flush <= fifo_recovery_param && cfg_wr &&
               ((sel_cap || sel_dc) && wval[pmdr_pkg::dc_flush]);
    end
  end

  //--------------------------------------------------------------
  // data fifo from backend to pci
  //--------------------------------------------------------------
  pmdr_fifo #(
    .width (32),
    .depth (fifo_depth)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (flush),
    .in_valid  (be_valid),
    .in_ready  (be_ready),
    .in_data   (be_data),
    .out_valid (pci_valid),
    .out_ready (pci_ready),
    .out_data  (pci_data),
    .level     (q_level)
  );

  //--------------------------------------------------------------
  // read mux and registered outputs
  //--------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= 32'h0000_0000;
      if (sel_hs) begin
        cfg_rdata <= {8'h00, hs_ins, hs_ext, 2'h0, hs_loo, hs_ins | hs_ext, hs_eim,
                      1'b0, 8'h00, pmdr_pkg::cap_id_hot_swap};
      end
      if (sel_cap) begin
        cfg_rdata <= {no_wait_timer_param, no_window_overflow_param, backend_access_param,
                      dma_regs_bar_param, dma_regs_location_param, pmdr_pkg::cap_size_master,
                      pmdr_pkg::cap_next_ptr, pmdr_pkg::cap_id_vendor};
      end
      if (sel_fs) begin
        // only bar 0 has an internal queue here; count saturates at 7
        cfg_rdata <= {8'h00, ext_fifo_nonempty[5], 3'h0, ext_fifo_nonempty[4], 3'h0,
                      ext_fifo_nonempty[3], 3'h0, ext_fifo_nonempty[2], 3'h0,
                      ext_fifo_nonempty[1], 3'h0, ext_fifo_nonempty[0],
                      (q_level > 5'd7) ? 3'h7 : q_level[2:0]};
      end
      if (sel_pa) begin
        cfg_rdata <= pci_addr;
      end
      if (sel_ba) begin
        cfg_rdata <= be_addr;
      end
      if (sel_bc) begin
        cfg_rdata <= byte_count;
      end
      if (sel_dc) begin
        cfg_rdata <= {dctl[31:26], 2'h0, dctl[23:16], ext_irq_en, ext_irq_stat,
                      dctl[13:12], 2'h0, dctl[9:0]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      enum_signal_mask <= 1'b0;
      led_on_off       <= 1'b0;
      irq_active       <= 1'b0;
      xfer_pci_addr    <= 32'h0000_0000;
      xfer_be_addr     <= 32'h0000_0000;
      pci_command      <= 4'h0;
      lane_enable_n    <= 8'h00;
      xfer_wide        <= 1'b0;
      backend_bar      <= 3'h0;
      xfer_active      <= 1'b0;
    end else begin
      enum_signal_mask <= hs_eim;
      led_on_off       <= hs_loo;
      irq_active       <= dctl[pmdr_pkg::dc_irq_stat] | ext_irq_stat;
      xfer_pci_addr    <= pci_addr;
      xfer_be_addr     <= be_addr;
      pci_command      <= dctl[7:4];
      lane_enable_n    <= dctl[23:16];
      xfer_wide        <= dctl[pmdr_pkg::dc_wide];
      backend_bar      <= dctl[28:26];
      xfer_active      <= request && (cnt_left != 32'h0);
    end
  end
endmodule

// file: verif/pmdr_regs_sva.sv
`timescale 1ns/1ps
module pmdr_regs_sva (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // register writes
  input wire logic        cfg_wr,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic        bus_master_en,
  // engine side
  input wire logic        xfer_start,
  input wire logic        xfer_active,
  input wire logic        xfer_end,
  input wire logic [3:0]  pci_command,
  input wire logic [7:0]  lane_enable_n,
  input wire logic        xfer_wide,
  input wire logic [2:0]  backend_bar,
  input wire logic [7:0]  burst_phases
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  wire       ctl_wr  = cfg_wr && cfg_addr == pmdr_pkg::ofs_dma_control;
  wire [3:0] w_cmd   = cfg_wdata[7:4];
  wire [3:0] w_lanes = cfg_wdata[19:16];
  wire [2:0] w_bar   = cfg_wdata[28:26];
  wire [2:0] w_burst = cfg_wdata[31:29];

  function automatic logic [7:0] phases_of(input logic [2:0] n);
    phases_of = (n == 3'h0) ? 8'h00 : 8'h01 << (n - 3'h1);
  endfunction

  // idle engine only: a set request cannot rise again
  sequence req_wr;
    ctl_wr && (&cfg_be[1:0]) && cfg_wdata[3] && cfg_wdata[8] && !xfer_active && !xfer_start;
  endsequence
  // the active flag is a registered copy of request, so it trails the pulse
  sequence started;
    xfer_start ##1 xfer_active;
  endsequence
  sequence fin;
    xfer_end && xfer_active;
  endsequence

  AST_START: assert property (req_wr ##0 bus_master_en |=> started)
    else $error("request write did not start a transfer");
  AST_NO_BME: assert property (req_wr ##0 !bus_master_en |=> !xfer_start [*2])
    else $error("transfer started without bus master enable");
  AST_NEED_EN: assert property (ctl_wr && cfg_be[1] && !cfg_wdata[8] && !xfer_active
                                |=> !xfer_start)
    else $error("transfer started with enable bit clear");
  AST_PULSE: assert property (xfer_start |=> !xfer_start)
    else $error("start pulse longer than one cycle");
  AST_END: assert property (fin |-> ##[1:2] !xfer_active)
    else $error("request still set after transfer end");
  AST_CMD: assert property (ctl_wr && cfg_be[0] |=> ##1 pci_command == $past(w_cmd, 2))
    else $error("pci command differs from control field");
  AST_LANES: assert property (ctl_wr && cfg_be[2]
                              |=> ##1 lane_enable_n == {4'h0, $past(w_lanes, 2)})
    else $error("lane enables differ from control field");
  AST_BAR: assert property (ctl_wr && cfg_be[3] |=> ##1 backend_bar == $past(w_bar, 2))
    else $error("backend bar differs from control field");
  AST_BURST: assert property (ctl_wr && cfg_be[3]
                              |=> burst_phases == phases_of($past(w_burst)))
    else $error("burst limit wrong for burst field");
  AST_NARROW: assert property (!xfer_wide)
    else $error("wide transfer in narrow build");
endmodule

// file: verif/pmdr_engine_model.sv
`timescale 1ns/1ps
module pmdr_engine_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // scenario control
  input  wire logic       xfer_start,
  input  wire logic [1:0] end_code,
  input  wire logic       stall,
  // engine replies
  output logic            phase_done,
  output logic            xfer_end,
  output logic [1:0]      xfer_status,
  output logic            pci_ready
);
  logic [3:0] left;
  logic [4:0] pace;

  // ----------------
  // transfer sequencing
  // ----------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      left <= 4'h0;
    end else if (xfer_start) begin
      left <= 4'h7;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  // four data phases, a quiet cycle, then the end pulse
  assign phase_done  = left >= 4'h3 && left <= 4'h6;
  assign xfer_end    = left == 4'h1;
  // status is junk outside the end pulse so nobody relies on it
  assign xfer_status = xfer_end ? end_code : ~end_code ^ left[1:0];

  // ----------------
  // drain pacing
  // ----------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pace <= 5'h01;
    end else begin
      pace <= {pace[3:0], pace[4] ^ pace[2]};
    end
  end
  assign pci_ready = !stall && pace[0];
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        mclk, rstn, cfg_wr, cfg_rd, bus_master_en, extract_event, insert_event;
  logic        backend_irq_n, enum_signal_mask, led_on_off, irq_active, xfer_start;
  logic        xfer_wide, phase_done, xfer_end, be_valid, be_ready, pci_valid;
  logic        pci_ready, xfer_active, stall;
  logic [1:0]  xfer_status, end_code;
  logic [2:0]  backend_bar;
  logic [3:0]  cfg_be, pci_command;
  logic [5:0]  ext_fifo_nonempty;
  logic [7:0]  cfg_addr, lane_enable_n, burst_phases;
  logic [31:0] cfg_wdata, cfg_rdata, xfer_pci_addr, be_data, pci_data, xfer_be_addr;
  logic [31:0] v, d, a, q[$];
  int          bad_count, total_checks, seed, n;

  pmdr_regs dut_u (.mclk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .bus_master_en, .extract_event, .insert_event, .backend_irq_n,
    .ext_fifo_nonempty, .enum_signal_mask, .led_on_off, .irq_active, .xfer_start,
    .xfer_pci_addr, .pci_command, .lane_enable_n, .xfer_wide, .backend_bar,
    .burst_phases, .phase_done, .xfer_end, .xfer_status, .be_valid, .be_ready,
    .be_data, .pci_valid, .pci_ready, .pci_data, .xfer_be_addr, .xfer_active);
  pmdr_engine_model far_u (.mclk, .rstn, .xfer_start, .end_code, .stall,
    .phase_done, .xfer_end, .xfer_status, .pci_ready);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------
  // checking and bus tasks
  // ----------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a8, input logic [31:0] dd);
    cfg_wr <= 1'b1;
    cfg_addr <= a8;
    cfg_wdata <= dd;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a8, output logic [31:0] dd);
    cfg_rd <= 1'b1;
    cfg_addr <= a8;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    @(negedge mclk);
    dd = cfg_rdata;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [7:0] a8, input logic [31:0] exp);
    logic [31:0] got;
    rd(a8, got);
    chk(got, exp);
  endtask
  function automatic logic [31:0] fstat(input int cnt);
    fstat = 32'h0;
    for (int i = 0; i < 6; i++)
      fstat[4*i+3] = ext_fifo_nonempty[i];
    fstat[2:0] = cnt > 7 ? 3'h7 : 3'(cnt);
  endfunction
  task automatic fill(input int max);
    n = 0;
    d = $random(seed);
    for (int i = 0; i < max; i++) begin
      be_valid <= 1'b1;
      be_data <= d;
      @(posedge mclk);
      if (be_ready) begin
        q.push_back(d);
        n++;
        d = $random(seed);
      end
    end
    be_valid <= 1'b0;
  endtask

  // drained words must match the order they went in
  always @(posedge mclk) begin
    if (rstn && pci_valid && pci_ready)
      chk(pci_data, q.size() > 0 ? q.pop_front() : ~pci_data);
  end

  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    stop_test();
  end

  // ----------------
  // main sequence
  // ----------------
  initial begin
    seed = 32'hd955;
    {rstn, cfg_wr, cfg_rd, extract_event, insert_event, be_valid, stall} = 7'h00;
    {cfg_addr, cfg_be, cfg_wdata, be_data, end_code} = {8'h00, 4'hF, 64'h0, 2'h0};
    {bus_master_en, backend_irq_n, ext_fifo_nonempty} = {2'h3, 6'h00};
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rc(pmdr_pkg::ofs_vendor_cap, 32'h2118_4009);
    rc(pmdr_pkg::ofs_hot_swap, 32'h0000_0006);
    wr(8'h44, 32'hFFFF_FFFF);
    rc(8'h44, 32'h0);
    for (int k = 22; k < 24; k++) begin
      if (k == 22) extract_event <= 1'b1;
      else insert_event <= 1'b1;
      @(posedge mclk);
      {extract_event, insert_event} <= 2'h0;
      @(posedge mclk);
      rc(pmdr_pkg::ofs_hot_swap, 32'h0004_0006 | (32'h1 << k));
      wr(pmdr_pkg::ofs_hot_swap, 32'h1 << k);
      rc(pmdr_pkg::ofs_hot_swap, 32'h0000_0006);
    end
    wr(pmdr_pkg::ofs_hot_swap, 32'hFFFF_FFFF);
    rc(pmdr_pkg::ofs_hot_swap, 32'h000A_0006);
    chk({30'h0, enum_signal_mask, led_on_off}, 32'h3);
    wr(pmdr_pkg::ofs_hot_swap, 32'h0);
    d = $random(seed);
    wr(pmdr_pkg::ofs_pci_addr, d);
    rc(pmdr_pkg::ofs_pci_addr, d);
    wr(pmdr_pkg::ofs_be_addr, ~d);
    rc(pmdr_pkg::ofs_be_addr, ~d & 32'h000F_FFFC);
    wr(pmdr_pkg::ofs_byte_count, d & 32'h0000_0FFF);
    rc(pmdr_pkg::ofs_byte_count, d & 32'h0000_0FFC);
    // every burst code, with read-only and clear-on-one bits thrown in
    for (int i = 0; i < 8; i++) begin
      v = ($random(seed) & 32'h1C0F_A1F0) | 32'h100 | (i << 29);
      wr(pmdr_pkg::ofs_dma_control, v | 32'h03F0_5E00);
      rc(pmdr_pkg::ofs_dma_control, v);
    end
    // one transfer per ending status; poll instead of touching control
    for (int s = 0; s < 4; s++) begin
      a = $random(seed) & 32'h000F_FFFC;
      wr(pmdr_pkg::ofs_pci_addr, a);
      wr(pmdr_pkg::ofs_be_addr, a);
      end_code <= 2'(s);
      v = 32'h0000_0178 | (s[0] ? 32'h2000 : 32'h0);
      wr(pmdr_pkg::ofs_dma_control, v);
      d = 32'h8;
      for (int t = 0; t < 30 && d[3]; t++)
        rd(pmdr_pkg::ofs_dma_control, d);
      if (d[3]) begin
        bad_count++;
        stop_test();
      end
      chk(d, (v & ~32'h8) | 32'h4 | s | {v[13], 12'h0});
      chk({31'h0, irq_active}, {31'h0, v[13]});
      rc(pmdr_pkg::ofs_pci_addr, a + 32'h10);
      rc(pmdr_pkg::ofs_be_addr, (a + 32'h10) & 32'h000F_FFFC);
      chk(xfer_pci_addr, a + 32'h10);
      chk(xfer_be_addr, (a + 32'h10) & 32'h000F_FFFC);
      wr(pmdr_pkg::ofs_dma_control, 32'h1000);
      rc(pmdr_pkg::ofs_dma_control, 32'h0);
    end
    bus_master_en <= 1'b0;
    wr(pmdr_pkg::ofs_dma_control, 32'h178);
    rc(pmdr_pkg::ofs_dma_control, 32'h170);
    bus_master_en <= 1'b1;
    wr(pmdr_pkg::ofs_dma_control, 32'h078);
    rc(pmdr_pkg::ofs_dma_control, 32'h070);
    // backend interrupt latched only while enabled
    for (int j = 0; j < 2; j++) begin
      wr(pmdr_pkg::ofs_dma_control, j ? 32'h4000 : 32'h8000);
      backend_irq_n <= 1'b0;
      repeat (3) @(posedge mclk);
      backend_irq_n <= 1'b1;
      rc(pmdr_pkg::ofs_dma_control, j ? 32'h0 : 32'hC000);
      chk({31'h0, irq_active}, {31'h0, j == 0});
    end
    ext_fifo_nonempty <= 6'($random(seed));
    stall <= 1'b1;
    fill(20);
    chk(n, 16);
    rc(pmdr_pkg::ofs_fifo_status, fstat(16));
    stall <= 1'b0;
    for (int t = 0; t < 300 && q.size() > 0; t++)
      @(posedge mclk);
    chk(q.size(), 0);
    rc(pmdr_pkg::ofs_fifo_status, fstat(0));
    // flush through both registers while the drain is stalled
    for (int j = 0; j < 2; j++) begin
      stall <= 1'b1;
      fill(3);
      rc(pmdr_pkg::ofs_fifo_status, fstat(3));
      wr(j ? pmdr_pkg::ofs_dma_control : pmdr_pkg::ofs_vendor_cap, 32'h400);
      q.delete();
      stall <= 1'b0;
      repeat (8) @(posedge mclk);
      rc(pmdr_pkg::ofs_fifo_status, fstat(0));
      chk({31'h0, pci_valid}, 32'h0);
    end
    stop_test();
  end
endmodule

bind pmdr_regs pmdr_regs_sva sva_u (.mclk, .rstn, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
  .bus_master_en, .xfer_start, .xfer_active, .xfer_end, .pci_command, .lane_enable_n,
  .xfer_wide, .backend_bar, .burst_phases);
